// ==== shared/afxh_params.svh ====
/*
 * Constants of the strobe-driving host for an asynchronous 9-bit
 * first-in/first-out memory: register offsets, field positions,
 * reset values and strobe timing counts.
 * Assumes inclusion by bare name from design files on a 100 MHz clock.
 */
`ifndef AFXH_PARAMS_SVH
`define AFXH_PARAMS_SVH

// ---------------------------------------------------------------
// Register word offsets (byte addresses)
// ---------------------------------------------------------------
`define AFXH_OFF_CTRL 12'h000
`define AFXH_OFF_WDATA 12'h004
`define AFXH_OFF_RDATA 12'h008
`define AFXH_OFF_STATUS 12'h00C

// ---------------------------------------------------------------
// Control fields
// ---------------------------------------------------------------
`define AFXH_CTRL_RESET 0
`define AFXH_CTRL_RETX 1
`define AFXH_CTRL_READ 2
`define AFXH_CTRL_FIRST 3
`define AFXH_CTRL_DEPTH 4
`define AFXH_CTRL_RESET_VAL 32'h0000_0000

// ---------------------------------------------------------------
// Status fields
// ---------------------------------------------------------------
`define AFXH_ST_BUSY 0
`define AFXH_ST_EMPTY 1
`define AFXH_ST_FULL 2
`define AFXH_ST_HALF 3
`define AFXH_ST_DONE 4

// ---------------------------------------------------------------
// Timing: strobe low and high widths, in ns and cycles
// ---------------------------------------------------------------
`define AFXH_CLK_NS 10
`define AFXH_PULSE_NS 30
`define AFXH_RECOV_NS 20
`define AFXH_PULSE_CYC ((`AFXH_PULSE_NS + `AFXH_CLK_NS - 1) / `AFXH_CLK_NS)
`define AFXH_RECOV_CYC ((`AFXH_RECOV_NS + `AFXH_CLK_NS - 1) / `AFXH_CLK_NS)
`define AFXH_CNT_W 4
`define AFXH_DATA_W 9

`endif

// ==== shared/afxh_pkg.sv ====
/*
 * Types of the strobe-driving host.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package afxh_pkg;

    typedef enum logic [2:0] {
        AFXH_IDLE,
        AFXH_RST_LOW,
        AFXH_STROBE_LOW,
        AFXH_STROBE_HIGH,
        AFXH_RECOVER
    } afxh_state_e;

    typedef enum logic [1:0] {
        AFXH_OP_RESET,
        AFXH_OP_RETX,
        AFXH_OP_WRITE,
        AFXH_OP_READ
    } afxh_op_e;

endpackage

// ==== hdl/afxh_host.sv ====
/*
 * Host that drives one asynchronous 9-bit first-in/first-out memory
 * through its write and read strobes, reset and retransmit pins, under
 * APB control. Status flags from the memory are synchronised here.
 * Assumes the memory's data outputs float while read strobe is high.
 */
// The implementer's own choices: the placing of the registers and register access over APB.
// How it works
// - Deep storage chains several memories; host serves one chain end.
// - Depth mode: first device gets first_load low; this host has no first_load pin, so the board straps it.
// - Depth mode: other devices keep first_load high.
// - Expansion output of each device feeds the next device's input.
// - Composite empty and full flags come from OR of all flags.
// - Width expansion: same controls to all; one device's flags suffice.
// - Writer strobes only while full flag is deasserted.
`timescale 1ns/1ps
`include "afxh_params.svh"

module afxh_host (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic fifo_write_n,
    output logic fifo_read_n,
    output logic fifo_reset_n,
    output logic fifo_retransmit_n,
    output logic [8:0] fifo_data_out,
    input wire logic [8:0] fifo_data_in,
    input wire logic empty_flag_n,
    input wire logic full_flag_n,
    input wire logic half_full_flag_n
);

    // ---------------------------------------------------------------
    // Register bus decode
    // ---------------------------------------------------------------
    logic [31:0] ctrl;
    logic [8:0] wdata;
    logic [8:0] rdata;
    logic done;
    afxh_pkg::afxh_state_e state;
    afxh_pkg::afxh_state_e next_state;
    afxh_pkg::afxh_op_e op;
    logic [`AFXH_CNT_W-1:0] cnt;

    wire access = psel && penable;
    wire hit_ctrl = paddr == `AFXH_OFF_CTRL;
    wire hit_wdata = paddr == `AFXH_OFF_WDATA;
    wire hit_rdata = paddr == `AFXH_OFF_RDATA;
    wire hit_status = paddr == `AFXH_OFF_STATUS;
    wire hit_any = hit_ctrl || hit_wdata || hit_rdata || hit_status;
    wire idle = state == afxh_pkg::AFXH_IDLE;
    wire wr_ctrl = access && pwrite && hit_ctrl;
    wire wr_wdata = access && pwrite && hit_wdata;
    // One chain end only; chaining and strapping stay on the board
    wire depth_mode = ctrl[`AFXH_CTRL_DEPTH];

    // ---------------------------------------------------------------
    // Flag and read-data synchronisers
    // ---------------------------------------------------------------
    logic [2:0] flag_meta;
    logic [2:0] flag_sync;
    logic [8:0] data_meta;
    logic [8:0] data_sync;
    // Flags are composite or taken from any one parallel device
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_meta <= 3'h0;
            flag_sync <= 3'h0;
            data_meta <= 9'h000;
            data_sync <= 9'h000;
        end else begin
            flag_meta <= {half_full_flag_n, full_flag_n, empty_flag_n};
            flag_sync <= flag_meta;
            data_meta <= fifo_data_in;
            data_sync <= data_meta;
        end
    end
    wire empty_n_s = flag_sync[0];
    wire full_n_s = flag_sync[1];
    // Half-full is meaningless in depth mode, so it reads as high
    wire half_n_s = flag_sync[2] || depth_mode;

    // Orders that would break the flag protocol are dropped
    wire start_write = wr_wdata && idle && full_n_s;
    wire ctrl_read = wr_ctrl && pwdata[`AFXH_CTRL_READ];
    wire start_read = ctrl_read && idle && empty_n_s;
    wire start_reset = wr_ctrl && idle && pwdata[`AFXH_CTRL_RESET];
    wire start_retx = wr_ctrl && idle && pwdata[`AFXH_CTRL_RETX]
        && !pwdata[`AFXH_CTRL_DEPTH];

    assign pready = 1'b1;
    assign pslverr = access && !hit_any;

    wire [31:0] status_word = {27'h0, done, !half_n_s, !full_n_s,
        !empty_n_s, !idle};
    wire [31:0] rd_mux = hit_ctrl ? ctrl :
        hit_wdata ? {23'h0, wdata} :
        hit_rdata ? {23'h0, rdata} :
        hit_status ? status_word : 32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rd_mux;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= `AFXH_CTRL_RESET_VAL;
        end else if (wr_ctrl) begin
            ctrl <= {27'h0, pwdata[`AFXH_CTRL_DEPTH],
                pwdata[`AFXH_CTRL_FIRST], 3'h0};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdata <= 9'h000;
        end else if (start_write) begin
            wdata <= pwdata[8:0];
        end
    end

    // ---------------------------------------------------------------
    // Strobe sequencer
    // ---------------------------------------------------------------
    wire cnt_end = cnt == `AFXH_CNT_W'(`AFXH_PULSE_CYC - 1);
    wire rec_end = cnt == `AFXH_CNT_W'(`AFXH_RECOV_CYC - 1);

    always_comb begin
        next_state = state;
        case (state)
            afxh_pkg::AFXH_IDLE: begin
                if (start_reset) begin
                    next_state = afxh_pkg::AFXH_RST_LOW;
                end else if (start_write || start_read || start_retx) begin
                    next_state = afxh_pkg::AFXH_STROBE_LOW;
                end
            end
            afxh_pkg::AFXH_RST_LOW,
            afxh_pkg::AFXH_STROBE_LOW: begin
                if (cnt_end) begin
                    next_state = afxh_pkg::AFXH_RECOVER;
                end
            end
            afxh_pkg::AFXH_RECOVER: begin
                if (rec_end) begin
                    next_state = afxh_pkg::AFXH_IDLE;
                end
            end
            default: next_state = afxh_pkg::AFXH_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= afxh_pkg::AFXH_IDLE;
            cnt <= '0;
        end else begin
            state <= next_state;
            cnt <= (next_state != state) ? '0 : cnt + 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op <= afxh_pkg::AFXH_OP_RESET;
        end else if (idle) begin
            if (start_reset) begin
                op <= afxh_pkg::AFXH_OP_RESET;
            end else if (start_write) begin
                op <= afxh_pkg::AFXH_OP_WRITE;
            end else if (start_read) begin
                op <= afxh_pkg::AFXH_OP_READ;
            end else if (start_retx) begin
                op <= afxh_pkg::AFXH_OP_RETX;
            end
        end
    end

    wire low_phase = state == afxh_pkg::AFXH_STROBE_LOW;
    wire rst_phase = state == afxh_pkg::AFXH_RST_LOW;

    // Strobes all high around reset and retransmit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fifo_write_n <= 1'b1;
            fifo_read_n <= 1'b1;
            fifo_reset_n <= 1'b1;
            fifo_retransmit_n <= 1'b1;
        end else begin
            fifo_reset_n <= !(next_state == afxh_pkg::AFXH_RST_LOW);
            fifo_write_n <= !(next_state == afxh_pkg::AFXH_STROBE_LOW
                && (idle ? start_write : op == afxh_pkg::AFXH_OP_WRITE));
            fifo_read_n <= !(next_state == afxh_pkg::AFXH_STROBE_LOW
                && (idle ? start_read : op == afxh_pkg::AFXH_OP_READ));
            fifo_retransmit_n <= !(next_state
                == afxh_pkg::AFXH_STROBE_LOW && (idle ? (start_retx
                && !start_write && !start_read)
                : op == afxh_pkg::AFXH_OP_RETX));
        end
    end

    // Data held across the rising write edge, where the word is stored
    assign fifo_data_out = wdata;

    // Read word sampled just before the read strobe rises; the word
    // settles at the strobe's fall, so the two-stage copy is valid by then
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata <= 9'h000;
            done <= 1'b0;
        end else begin
            if (low_phase && cnt_end && op == afxh_pkg::AFXH_OP_READ) begin
                rdata <= data_sync;
            end
            if (state == afxh_pkg::AFXH_RECOVER && rec_end) begin
                done <= 1'b1;
            end else if (!idle || start_write || start_read) begin
                done <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    sequence s_wr_low;
        !fifo_write_n [*3];
    endsequence

    chk_write_width: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(fifo_write_n) |-> s_wr_low ##1 fifo_write_n)
        else $error("write strobe width wrong");

    chk_write_full: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(fifo_write_n) |-> $past(full_n_s))
        else $error("write started while full");

    chk_read_empty: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(fifo_read_n) |-> $past(empty_n_s))
        else $error("read started while empty");

    chk_retx_strobes: assert property (@(posedge pclk)
        disable iff (!presetn)
        !fifo_retransmit_n |-> fifo_read_n && fifo_write_n
        && fifo_reset_n)
        else $error("strobe low during retransmit");

    chk_retx_depth: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(fifo_retransmit_n) |-> !$past(depth_mode))
        else $error("retransmit in depth mode");

    chk_reset_quiet: assert property (@(posedge pclk)
        disable iff (!presetn)
        !fifo_reset_n |-> fifo_read_n && fifo_write_n)
        else $error("strobe low during reset");

    chk_data_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !fifo_write_n |=> $stable(fifo_data_out))
        else $error("write data moved under strobe");

    chk_read_done: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(fifo_read_n) |-> ##2 done)
        else $error("read did not finish");

endmodule

// ==== test/afxh_fifo_model.sv ====
/*
 * Behavioural model of one 9-bit strobe-driven first-in/first-out memory.
 * Assumes strobes come from the host; outputs change only on strobe, reset and retransmit edges.
 */
`timescale 1ns/1ps

module afxh_fifo_model #(
    parameter int DEPTH = 8
) (
    input wire logic write_n,
    input wire logic read_n,
    input wire logic reset_n,
    input wire logic retransmit_n,
    input wire logic [8:0] data_in,
    output logic [8:0] data_out,
    output logic empty_n,
    output logic full_n,
    output logic half_n
);
    logic [8:0] mem [DEPTH];
    int wp = 0;
    int rp = 0;
    int cnt = 0;
    logic wr_ok = 1'b0;
    logic rd_ok = 1'b0;

    initial data_out = 9'h155;
    // ---------------------------------------------------------------
    // Pointers and flags
    // ---------------------------------------------------------------
    always @(negedge reset_n) begin
        wp = 0;
        rp = 0;
        cnt = 0;
    end
    // Assumes no wrap since reset, as retransmit itself requires
    always @(negedge retransmit_n) if (reset_n) begin
        cnt = cnt + rp;
        rp = 0;
    end
    always @(negedge write_n) wr_ok = reset_n && full_n;
    always @(posedge write_n) if (wr_ok && reset_n) begin
        mem[wp] = data_in;
        wp = (wp + 1) % DEPTH;
        cnt = cnt + 1;
    end
    always @(negedge read_n) begin
        rd_ok = reset_n && empty_n;
        if (rd_ok) data_out = mem[rp];
    end
    // Released bus shows the inverse, never a stale copy
    always @(posedge read_n) begin
        data_out = ~data_out;
        if (rd_ok && reset_n) begin
            rp = (rp + 1) % DEPTH;
            cnt = cnt - 1;
        end
    end
    assign empty_n = (cnt != 0);
    assign full_n = (cnt != DEPTH);
    assign half_n = !(cnt > DEPTH / 2);
endmodule

// ==== test/testbench.sv ====
/*
 * Self-checking bench: APB master driving the host, memory model beyond.
 * Assumes the host and its parameter header compile ahead of this file.
 */
`timescale 1ns/1ps
`include "afxh_params.svh"

module testbench;
    localparam int DEPTH = 8;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd, w;
    logic pready, pslverr, rerr;
    logic wr_n, rdn, rst_n, rtx_n, ef_n, ff_n, hf_n;
    logic [8:0] d_to_mem, d_from_mem;
    logic [8:0] q[$];
    int fail_count = 0;
    int total_checks = 0;
    int cycles = 0;

    afxh_host u_afxh_host (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .fifo_write_n(wr_n), .fifo_read_n(rdn), .fifo_reset_n(rst_n),
        .fifo_retransmit_n(rtx_n), .fifo_data_out(d_to_mem),
        .fifo_data_in(d_from_mem), .empty_flag_n(ef_n),
        .full_flag_n(ff_n), .half_full_flag_n(hf_n));
    afxh_fifo_model #(.DEPTH(DEPTH)) u_afxh_fifo_model (.write_n(wr_n),
        .read_n(rdn), .reset_n(rst_n), .retransmit_n(rtx_n),
        .data_in(d_to_mem), .data_out(d_from_mem), .empty_n(ef_n),
        .full_n(ff_n), .half_n(hf_n));

    initial forever #5 pclk = ~pclk;
    // ---------------------------------------------------------------
    // Hang guard and helpers
    // ---------------------------------------------------------------
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            $display("MISMATCH at %0t: timeout", $time);
            finish_test();
        end
    end
    task finish_test;
        $display("Checks %0d, mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task check(input logic [31:0] got, input logic [31:0] exp, string s);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t: %s got %0h exp %0h", $time, s, got,
                exp);
        end
    endtask
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Waits out busy, then two cycles for the flag synchronisers
    task order(input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        apb(1'b1, a, d);
        rd = 32'h0000_0001;
        while (rd[`AFXH_ST_BUSY] !== 1'b0 && n < 40) begin
            apb(1'b0, `AFXH_OFF_STATUS, 32'h0000_0000);
            n++;
        end
        repeat (2) @(posedge pclk);
    endtask
    function automatic logic [2:0] exp_st(int n);
        return {n > DEPTH / 2, n == DEPTH, n == 0};
    endfunction
    task chk_st(input int n, string s);
        apb(1'b0, `AFXH_OFF_STATUS, 32'h0000_0000);
        check({29'h0, rd[3:1]}, {29'h0, exp_st(n)}, s);
    endtask
    task rd_word;
        order(`AFXH_OFF_CTRL, 32'h0000_0004);
        apb(1'b0, `AFXH_OFF_RDATA, 32'h0000_0000);
    endtask
    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        void'($urandom(32'hEB06716D));
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `AFXH_OFF_CTRL, 32'h0000_0000);
        check(rd, `AFXH_CTRL_RESET_VAL, "ctrl reset value");
        apb(1'b0, 12'h010, 32'h0000_0000);
        check({31'h0, rerr}, 32'h0000_0001, "unmapped error");
        order(`AFXH_OFF_CTRL, 32'h0000_0001);
        chk_st(0, "after memory reset");
        $display("Test reset done");
        for (int i = 0; i <= DEPTH; i++) begin
            w = $urandom;
            order(`AFXH_OFF_WDATA, w);
            if (i < DEPTH) q.push_back(w[8:0]);
            chk_st(q.size(), "fill");
        end
        for (int i = 0; i <= DEPTH; i++) begin
            rd_word();
            if (i < DEPTH) check(rd[8:0], q.pop_front(), "drain");
            chk_st(q.size(), "drain status");
        end
        $display("Test fill and drain done");
        for (int i = 0; i < 3; i++) begin
            w = $urandom;
            order(`AFXH_OFF_WDATA, w);
            q.push_back(w[8:0]);
        end
        rd_word();
        check(rd[8:0], q[0], "first after wrap");
        order(`AFXH_OFF_CTRL, 32'h0000_0002);
        chk_st(3, "retransmit count");
        for (int i = 0; i < 3; i++) begin
            rd_word();
            check(rd[8:0], q.pop_front(), "replay");
        end
        $display("Test retransmit done");
        order(`AFXH_OFF_CTRL, 32'h0000_0018);
        order(`AFXH_OFF_WDATA, 32'h0000_01A5);
        rd_word();
        check(rd[8:0], 9'h1A5, "depth word");
        order(`AFXH_OFF_CTRL, 32'h0000_001A);
        chk_st(0, "depth retransmit ignored");
        order(`AFXH_OFF_WDATA, 32'h0000_005A);
        order(`AFXH_OFF_CTRL, 32'h0000_0019);
        chk_st(0, "depth reset");
        $display("Test depth mode done");
        finish_test();
    end
endmodule
